// ---- hw/bdir_line_if.sv ----
// Interface carrying synchronised bus levels and bus events.
`default_nettype none
interface bdir_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport source (output scl, sda, scl_rise, scl_fall, start, stop);
  modport sink   (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ---- hw/bdir_line_sync.sv ----
// Synchroniser and start, stop and clock edge detector for the bus pins.
`default_nettype none
module bdir_line_sync
  import bdir_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  bdir_line_if.source ln
);
  typedef struct packed {
    logic [1:0] scl_s1;
    logic [1:0] scl_s2;
    logic [1:0] prev;
  } bdir_sync_t;

  bdir_sync_t r;
  bdir_sync_t n;

  // Two stages per pin, then one stage of history for edge detection.
  always_comb begin
    n.scl_s1 = {scl_i, sda_i};
    n.scl_s2 = r.scl_s1;
    n.prev   = r.scl_s2;
  end

  // Lines idle high, so reset to high to avoid a false event.
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{default: 2'h3};
    end else begin
      r <= n;
    end
  end

  // Events only look at the second stage and its history.
  assign ln.scl      = r.scl_s2[1];
  assign ln.sda      = r.scl_s2[0];
  assign ln.scl_rise = r.scl_s2[1] & ~r.prev[1];
  assign ln.scl_fall = ~r.scl_s2[1] & r.prev[1];
  assign ln.start    = r.scl_s2[1] & r.prev[1] & r.prev[0] & ~r.scl_s2[0];
  assign ln.stop     = r.scl_s2[1] & r.prev[1] & ~r.prev[0] & r.scl_s2[0];
endmodule
`default_nettype wire

// ---- hw/bdir_pkg.sv ----
// Package of constants and types for the broadcast data two-wire readout.
`default_nettype none
package bdir_pkg;
  // Seven-bit slave address with the select bit at zero (write 0x20).
  localparam logic [6:0] BDIR_ADDR_BASE = 7'h10;
  // Bit positions inside the mode select control byte.
  localparam int BDIR_FMT_BIT   = 0;
  localparam int BDIR_MODE_BIT  = 1;
  localparam int BDIR_HDR_BIT   = 2;
  localparam int BDIR_ORDER_BIT = 3;
  localparam logic [7:0] BDIR_CTRL_RESET = 8'h00;
  // Read path geometry.
  localparam int         BDIR_STORE_DEPTH = 64;
  localparam logic [3:0] BDIR_PTR_LAST    = 4'hF;
  localparam logic [3:0] BDIR_BITS_BYTE   = 4'h8;
  localparam logic [3:0] BDIR_HALF_SLOTS  = 4'h8;
  // Source byte numbers per output slot, slot 0 rightmost.
  localparam logic [7:0][5:0] BDIR_F1_SRC =
    {6'h0D, 6'h15, 6'h14, 6'h13, 6'h12, 6'h11, 6'h10, 6'h0F};
  localparam logic [5:0][5:0] BDIR_F2_HI =
    {6'h18, 6'h0E, 6'h16, 6'h14, 6'h12, 6'h10};
  localparam logic [5:0][5:0] BDIR_F2_LO =
    {6'h19, 6'h0F, 6'h17, 6'h15, 6'h13, 6'h11};
  localparam logic [5:0][5:0] BDIR_L16_SRC =
    {6'h0F, 6'h05, 6'h0E, 6'h0D, 6'h0C, 6'h0B};
  localparam logic [5:0] BDIR_F2_LAST_SRC  = 6'h0D;
  localparam logic [3:0] BDIR_F2_SLOTS     = 4'h6;
  localparam logic [3:0] BDIR_F2_LAST_SLOT = 4'h6;
  localparam logic [3:0] BDIR_F1_SLOTS     = 4'h8;
  // First source byte of each header half in both orders.
  localparam logic [5:0] BDIR_HDR_A_FIRST  = 6'h26;
  localparam logic [5:0] BDIR_HDR_A_SECOND = 6'h1E;
  localparam logic [5:0] BDIR_HDR_B_FIRST  = 6'h16;
  localparam logic [5:0] BDIR_HDR_B_SECOND = 6'h0E;
  localparam logic [7:0] BDIR_FILL = 8'hFF;

  typedef enum logic [2:0] {
    BDIR_IDLE     = 3'h0,
    BDIR_ADDR     = 3'h1,
    BDIR_ADDR_ACK = 3'h3,
    BDIR_TX       = 3'h2,
    BDIR_MACK     = 3'h6,
    BDIR_WR       = 3'h7,
    BDIR_WR_ACK   = 3'h5
  } bdir_state_t;
endpackage
`default_nettype wire

// ---- hw/bdir_readout.sv ----
// Two-wire slave read path of the broadcast data decoder.
// Summary of operation
// - Header select bit low gives format 1 data, high gives header bytes.
// - Order bit low: header 38-45 then 30-37; high: 22-29 then 14-21.
// - A read addresses at most 16 slots, mapped by the active mode; the pointer holds at slot 16.
// - A start condition clears the output byte pointer.
// - Matching read address is acknowledged low, then the slave transmits.
// - Pointed byte goes out on the next eight clocks, top bit first.
// - Master acknowledge advances the pointer and sends the next byte.
// - Missing master acknowledge releases the line and ends transmission.
// - Every source byte is bit-reversed before it is placed in a slot.
// - Format 1: slots 1-7 hold bytes 15-21, slot 8 holds byte 13.
// - Format 2: nibble pairs per slot; slot 7 holds byte 13 over ones.
// - Line 16: slots 1-6 hold bytes 11,12,13,14,5,15; slot 7 all ones.
// - Addresses 0x20/0x21 with select low, 0x22/0x23 with select high.
// - Control bit 0 picks format 2 (0) or format 1/header (1).
// - Control bit 1 picks line 16 mode (0) or packet mode (1).
// - Store writes arriving while a bus access is in progress are dropped, not applied later.
`default_nettype none
module bdir_readout
  import bdir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       address_select_input,
  input  wire logic       acq_we,
  input  wire logic [5:0] acq_addr,
  input  wire logic [7:0] acq_data,
  output logic            acq_hold,
  output logic [7:0]      mode_select_control
);
  typedef struct packed {
    bdir_state_t                              st;
    logic [3:0]                               cnt;
    logic [7:0]                               sh;
    logic [3:0]                               ptr;
    logic                                     rd;
    logic                                     macked;
    logic                                     drv;
    logic [7:0]                               ctrl;
    logic                                     sel_s1;
    logic                                     sel_s2;
    logic [BDIR_STORE_DEPTH-1:0][7:0]         store;
  } bdir_core_t;

  bdir_core_t  r;
  bdir_core_t  n;
  bdir_line_if ln ();

  bdir_line_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ln    (ln)
  );

  // Reverses bit order so source bit 0 leaves first.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      o[7-i] = v[i];
    end
    return o;
  endfunction

  // Builds the output byte for one slot from the store and control byte.
  function automatic logic [7:0] map_byte(
    input logic [7:0]                      ctrl,
    input logic [3:0]                      ptr,
    input logic [BDIR_STORE_DEPTH-1:0][7:0] st
  );
    logic [5:0] idx;
    logic [2:0] low;
    logic [7:0] hi;
    logic [7:0] lo;
    idx = 6'h00;
    low = ptr[2:0];
    hi  = 8'h00;
    lo  = 8'h00;
    map_byte = BDIR_FILL;
    if (!ctrl[BDIR_MODE_BIT]) begin
      if (ptr < BDIR_F2_SLOTS) begin
        map_byte = rev8(st[BDIR_L16_SRC[ptr]]);
      end
    end else if (!ctrl[BDIR_FMT_BIT]) begin
      if (ptr < BDIR_F2_SLOTS) begin
        hi = rev8(st[BDIR_F2_HI[ptr]]);
        lo = rev8(st[BDIR_F2_LO[ptr]]);
        map_byte = {hi[7:4], lo[7:4]};
      end else if (ptr == BDIR_F2_LAST_SLOT) begin
        hi = rev8(st[BDIR_F2_LAST_SRC]);
        map_byte = {hi[7:4], 4'hF};
      end
    end else if (!ctrl[BDIR_HDR_BIT]) begin
      if (ptr < BDIR_F1_SLOTS) begin
        map_byte = rev8(st[BDIR_F1_SRC[low]]);
      end
    end else begin
      // Header bytes run in two halves of eight consecutive bytes.
      if (!ctrl[BDIR_ORDER_BIT]) begin
        idx = (ptr < BDIR_HALF_SLOTS) ? BDIR_HDR_A_FIRST : BDIR_HDR_A_SECOND;
      end else begin
        idx = (ptr < BDIR_HALF_SLOTS) ? BDIR_HDR_B_FIRST : BDIR_HDR_B_SECOND;
      end
      map_byte = rev8(st[idx + {3'h0, low}]);
    end
  endfunction

  // Bus protocol engine, control register and acquisition store.
  always_comb begin
    n = r;
    // The select strap is a pin, so it passes two stages before use.
    n.sel_s1 = address_select_input;
    n.sel_s2 = r.sel_s1;
    // New data lands only while the bus is untouched.
    if (acq_we && r.st == BDIR_IDLE && !ln.start) begin
      n.store[acq_addr] = acq_data;
    end
    if (ln.start) begin
      n.st  = BDIR_ADDR;
      n.cnt = 4'h0;
      n.ptr = 4'h0;
      n.drv = 1'b0;
    end else if (ln.stop) begin
      n.st  = BDIR_IDLE;
      n.drv = 1'b0;
    end else begin
      case (r.st)
        BDIR_ADDR, BDIR_WR: begin
          if (ln.scl_rise) begin
            n.sh  = {r.sh[6:0], ln.sda};
            n.cnt = r.cnt + 4'h1;
          end else if (ln.scl_fall && r.cnt == BDIR_BITS_BYTE) begin
            n.cnt = 4'h0;
            if (r.st == BDIR_WR) begin
              n.ctrl = r.sh;
              n.drv  = 1'b1;
              n.st   = BDIR_WR_ACK;
            end else if (r.sh[7:1] ==
                         (BDIR_ADDR_BASE | {6'h00, r.sel_s2})) begin
              n.rd  = r.sh[0];
              n.drv = 1'b1;
              n.st  = BDIR_ADDR_ACK;
            end else begin
              n.st = BDIR_IDLE;
            end
          end
        end
        BDIR_ADDR_ACK: begin
          if (ln.scl_fall) begin
            if (r.rd) begin
              n.sh  = map_byte(r.ctrl, r.ptr, r.store);
              n.drv = ~n.sh[7];
              n.st  = BDIR_TX;
            end else begin
              n.drv = 1'b0;
              n.st  = BDIR_WR;
            end
          end
        end
        BDIR_TX: begin
          if (ln.scl_fall) begin
            if (r.cnt == BDIR_BITS_BYTE - 4'h1) begin
              n.cnt = 4'h0;
              n.drv = 1'b0;
              n.st  = BDIR_MACK;
            end else begin
              n.sh  = {r.sh[6:0], 1'b0};
              n.drv = ~r.sh[6];
              n.cnt = r.cnt + 4'h1;
            end
          end
        end
        BDIR_MACK: begin
          if (ln.scl_rise) begin
            n.macked = ~ln.sda;
          end else if (ln.scl_fall) begin
            if (r.macked) begin
              if (r.ptr != BDIR_PTR_LAST) begin
                n.ptr = r.ptr + 4'h1;
              end
              n.sh  = map_byte(r.ctrl, n.ptr, r.store);
              n.drv = ~n.sh[7];
              n.st  = BDIR_TX;
            end else begin
              n.drv = 1'b0;
              n.st  = BDIR_IDLE;
            end
          end
        end
        BDIR_WR_ACK: begin
          if (ln.scl_fall) begin
            n.drv = 1'b0;
            n.st  = BDIR_IDLE;
          end
        end
        default: begin
          n.drv = 1'b0;
        end
      endcase
    end
  end

  // Control byte clears to zero at power-up; the store starts empty.
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Open-drain line: only ever pulled low.
  assign sda_o               = 1'b0;
  assign sda_oe              = r.drv;
  assign acq_hold            = (r.st != BDIR_IDLE);
  assign mode_select_control = r.ctrl;
endmodule
`default_nettype wire

// ---- test/bdir_master.sv ----
// Bus master model driving the clock and pulling the data line.
`default_nettype none
module bdir_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines idle high.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Waits n clocks and steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One clock pulse; data is set only while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    tick(4);
    pull = ~b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl = 1'b0;
  endtask
  // Start, also used as a restart after a released byte.
  task automatic start();
    tick(4);
    pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    pull = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask
  // Stop: data rises with the clock high, both lines left high.
  task automatic stop();
    tick(4);
    pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    pull = 1'b0;
    tick(8);
  endtask
  // Eight bits top first, then the acknowledge slot (a low acknowledges).
  task automatic byte_x(input logic [7:0] w, input logic a,
                        output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(a, ar);
  endtask
endmodule
`default_nettype wire

// ---- test/bdir_readout_asserts.sv ----
// Checker of the readout pin behaviour against the bus pins.
`default_nettype none
module bdir_readout_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       acq_hold,
  input wire logic [7:0] mode_select_control
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pin relations; the data drive only ever changes while the clock is low.
  AST_LOW_ONLY: assert property (sda_oe |-> !sda_o && !sda_i)
    else $error("data line not low while driven");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=>
    !sda_oe && !acq_hold && mode_select_control == 8'h00)
    else $error("outputs not cleared by reset");
  AST_OE_SCL_LOW: assert property (!$stable(sda_oe) |-> !scl_i)
    else $error("data drive changed with clock high");
  AST_OE_STANDS: assert property (
    $rose(sda_oe) |=> $stable(sda_oe)[*4])
    else $error("data drive did not stand");
  AST_OE_IN_ACCESS: assert property (sda_oe |-> acq_hold)
    else $error("data driven outside an access");
  AST_CTRL_IN_ACCESS: assert property (
    !$stable(mode_select_control) |-> acq_hold)
    else $error("control changed outside an access");
  AST_HOLD_AT_START: assert property (
    $rose(acq_hold) |-> scl_i && !sda_i)
    else $error("hold rose without a start");
  AST_START_BUSY: assert property (
    scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] acq_hold)
    else $error("start not taken");
  AST_STOP_IDLE: assert property (
    scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !acq_hold)
    else $error("stop did not end the access");
  // Main scenarios reached.
  cover property ($rose(sda_oe));
  cover property (!$stable(mode_select_control));
  cover property ($fell(acq_hold));
endmodule
`default_nettype wire

// ---- test/broadcast_data_i2c_readout_test.sv ----
// Self-checking bench of the broadcast data readout.
`default_nettype none
module broadcast_data_i2c_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sel = 1'b0;
  logic       we = 1'b0;
  logic [5:0] wa = 6'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] cur = 8'h00;
  logic       scl, pull, sda_o, sda_oe, hold, ar;
  logic [7:0] ctrl, r;
  int         mismatches = 0;
  int         checked = 0;
  wire        sda = (sda_oe ? sda_o : 1'b1) & ~pull;
  always #50 clk = ~clk;
  bdir_readout u_dut (.clk, .rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
    .address_select_input(sel), .acq_we(we), .acq_addr(wa), .acq_data(wd),
    .acq_hold(hold), .mode_select_control(ctrl));
  bdir_master u_mst (.clk, .sda, .scl, .pull);
  // Stored byte pattern and bit reversal.
  function automatic logic [7:0] src(input int n);
    return 8'(n * 37 + 90);
  endfunction
  function automatic logic [7:0] rv(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rv[i] = v[7 - i];
  endfunction
  // Expected output byte k for control value c.
  function automatic logic [7:0] exp_slot(input logic [7:0] c, input int k);
    int         l16[6] = '{11, 12, 13, 14, 5, 15};
    int         f2[6] = '{16, 18, 20, 22, 14, 24};
    logic [7:0] a, b;
    a = rv(src(f2[k % 6]));
    b = rv(src(f2[k % 6] + 1));
    if (k == 6) begin
      a = rv(src(13));
      b = 8'hFF;
    end
    if (!c[1]) return k < 6 ? rv(src(l16[k])) : 8'hFF;
    if (!c[0]) return k < 7 ? {a[7:4], b[7:4]} : 8'hFF;
    if (!c[2]) return k < 7 ? rv(src(15 + k))
                            : k == 7 ? rv(src(13)) : 8'hFF;
    return rv(src((c[3] ? 22 : 38) + (k < 8 ? k : k - 16)));
  endfunction
  // Compares and counts.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One acquisition write strobe.
  task automatic store(input int n, input logic [7:0] d);
    @(posedge clk);
    #1;
    we = 1'b1;
    wa = 6'(n);
    wd = d;
    @(posedge clk);
    #1;
    we = 1'b0;
  endtask
  // Control write through the bus.
  task automatic wr(input logic [7:0] v);
    u_mst.start();
    u_mst.byte_x(8'h20 | {6'h00, sel, 1'b0}, 1'b1, r, ar);
    chk({7'h00, ar}, 8'h00);
    u_mst.byte_x(v, 1'b1, r, ar);
    chk({7'h00, ar}, 8'h00);
    u_mst.stop();
    cur = v;
    chk(ctrl, v);
  endtask
  // Read of n bytes, the last one refused, then a released byte.
  task automatic rd(input logic [7:0] a, input int n, input logic fin);
    logic na;
    u_mst.start();
    u_mst.byte_x(a, 1'b1, r, ar);
    chk({7'h00, ar},
        {7'h00, a != (8'h21 | {6'h00, sel, 1'b0})});
    for (int k = 0; k < n && !ar; k++) begin
      u_mst.byte_x(8'hFF, k == n - 1, r, na);
      chk(r, exp_slot(cur, k));
    end
    u_mst.byte_x(8'hFF, 1'b1, r, na);
    chk(r, 8'hFF);
    chk({7'h00, hold}, 8'h00);
    if (fin) u_mst.stop();
  endtask
  // Main sequence.
  initial begin
    logic [7:0] cfg[5] = '{8'h02, 8'h03, 8'h07, 8'h0F, 8'h00};
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(ctrl, 8'h00);
    for (int n = 0; n < 64; n++) store(n, src(n));
    rd(8'h21, 16, 1'b1);
    foreach (cfg[i]) begin
      wr(cfg[i]);
      rd(8'h21, 16, 1'b1);
    end
    wr(8'h03);
    u_mst.start();
    chk({7'h00, hold}, 8'h01);
    store(15, 8'h00);
    u_mst.stop();
    chk({7'h00, hold}, 8'h00);
    rd(8'h21, 1, 1'b0);
    rd(8'h21, 2, 1'b1);
    sel = 1'b1;
    rd(8'h21, 1, 1'b1);
    wr(8'h02);
    rd(8'h23, 3, 1'b1);
    finish_test();
  end
  // Cuts a hang short.
  initial begin
    #6000000;
    mismatches++;
    finish_test();
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
bind bdir_readout bdir_readout_asserts u_chk (.clk, .rst, .scl_i, .sda_i,
  .sda_o, .sda_oe, .acq_hold, .mode_select_control);
`default_nettype wire
